// >>> dpsp_pkg.sv
// Constants and types for the dual-port static memory port controller
// Overview of operation
// - Host holds write strobe high through every read cycle.
// - Flag reads use their own select sequence, never continuous select.
// - Upper lane: select low, upper lane low, flag space high; lower alike.
// - Host keeps write strobe or port select high while address changes.
// - Host leaves data bus undriven while device outputs may be on.
// - Port select stays high through flag write and read-back.
// - Flag request: write low on data bit 0 in flag space.
// - Secondary mode: busy is a device input gating that port's writes.
// - Flag access: port select high, flag space low; memory the reverse.
package dpsp_pkg;
  localparam int          ADDR_W     = 14;
  localparam int          DATA_W     = 16;
  localparam int          FLAG_AW    = 3;
  // Phase lengths in ns and the cycle counts derived at 125 MHz
  localparam int          CLK_PS     = 8000;
  localparam int          T_SETUP_NS = 8;
  localparam int          T_PULSE_NS = 25;
  localparam int          T_RECOV_NS = 16;
  localparam int          SETUP_CYC  =
    (T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int          PULSE_CYC  =
    (T_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int          RECOV_CYC  =
    (T_RECOV_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CNT_ONE    = 4'h1;
  localparam logic [1:0]  LANES_NONE = 2'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
  // Gray-coded sequence states
  typedef enum logic [2:0] {
    DPSP_IDLE  = 3'b000,
    DPSP_SETUP = 3'b001,
    DPSP_PULSE = 3'b011,
    DPSP_HOLD  = 3'b010,
    DPSP_RECOV = 3'b110
  } dpsp_state_t;
endpackage

// >>> dpsp_sync.sv
// Two flip-flop synchroniser for pin inputs, one per bit
`timescale 1ns/10ps
module dpsp_sync #(parameter int W = 1)
(
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  // First stage is read only by the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
        begin
          meta_reg[i] <= 1'b0;
          q_out[i]    <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= d_in[i];
          q_out[i]    <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule

// >>> dpsp_port_ctrl.sv
// Host-side access controller for one port of the dual-port memory
`timescale 1ns/10ps
module dpsp_port_ctrl
  import dpsp_pkg::*;
(
  // Clock and reset
  input  wire logic              MCLK_IN,
  input  wire logic              RST_N_IN,
  // User request
  input  wire logic              REQ_IN,
  input  wire logic              REQ_WRITE_IN,
  input  wire logic              REQ_FLAG_IN,
  input  wire logic [1:0]        REQ_LANES_IN,
  input  wire logic [ADDR_W-1:0] REQ_ADDR_IN,
  input  wire logic [DATA_W-1:0] REQ_WDATA_IN,
  // User answer
  output logic                   REQ_READY_OUT,
  output logic                   DONE_OUT,
  output logic [DATA_W-1:0]      RDATA_OUT,
  output logic                   BLOCKED_OUT,
  // Memory pins
  output logic [ADDR_W-1:0]      ADDR_OUT,
  output logic                   PORT_SEL_N_OUT,
  output logic                   WRITE_N_OUT,
  output logic                   OUT_EN_N_OUT,
  output logic                   UPPER_LANE_SEL_N_OUT,
  output logic                   LOWER_LANE_SEL_N_OUT,
  output logic                   FLAG_SPACE_SEL_N_OUT,
  input  wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0]      DATA_OUT,
  output logic                   DATA_OE_OUT,
  input  wire logic              BUSY_N_IN
);
  typedef struct packed {
    dpsp_state_t       st;
    logic [3:0]        cnt;
    logic              wr;
    logic              flag;
    logic [1:0]        lanes;
    logic              blocked;
    logic              ready;
    logic              done;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] addr;
    logic              sel_n;
    logic              we_n;
    logic              oe_n;
    logic              ub_n;
    logic              lb_n;
    logic              sem_n;
    logic [DATA_W-1:0] dout;
    logic              doe;
  } dpsp_regs_t;

  dpsp_regs_t        r_reg;
  dpsp_regs_t        r_next;
  logic [DATA_W-1:0] data_s;
  logic [0:0]        busy_n_s;

  // Read data and busy come from the far clockless device
  // Read data is used only as settled at pulse end; busy is sampled every pulse cycle
  dpsp_sync #(.W(DATA_W)) u_sync_data
  (
    .clk_in   (MCLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (DATA_IN),
    .q_out    (data_s)
  );
  dpsp_sync #(.W(1)) u_sync_busy
  (
    .clk_in   (MCLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (BUSY_N_IN),
    .q_out    (busy_n_s)
  );

  // Sequencer: setup with strobes off, pulse, hold, recovery
  always_comb
  begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    case (r_reg.st)
      DPSP_IDLE:
      begin
        // Address only moves here, with both strobes high
        // Requests while not ready are ignored, never queued
        if (REQ_IN && r_reg.ready)
        begin
          r_next.ready   = 1'b0;
          r_next.wr      = REQ_WRITE_IN;
          r_next.flag    = REQ_FLAG_IN;
          r_next.lanes   = REQ_LANES_IN;
          r_next.blocked = 1'b0;
          r_next.addr    = REQ_ADDR_IN;
          r_next.dout    = REQ_WDATA_IN;
          r_next.cnt     = 4'(SETUP_CYC);
          r_next.st      = DPSP_SETUP;
        end
      end

      DPSP_SETUP:
      begin
        // Address settles while every strobe is still high
        if (r_reg.cnt > CNT_ONE)
          r_next.cnt = r_reg.cnt - CNT_ONE;
        else
        begin
          // Selects fall with the write strobe, so outputs stay off
          r_next.we_n = !r_reg.wr;
          r_next.oe_n = r_reg.wr;
          // Drive the bus only once outputs are surely off
          r_next.doe  = r_reg.wr;
          if (r_reg.flag)
          begin
            // Flag space: port select stays high throughout
            r_next.sel_n = 1'b1;
            r_next.sem_n = 1'b0;
            // Flag bit rides on the lower lane, which must be low
            r_next.ub_n  = 1'b1;
            r_next.lb_n  = 1'b0;
          end
          else
          begin
            // Lanes latched at take; the user may move them meanwhile
            r_next.sel_n = 1'b0;
            r_next.sem_n = 1'b1;
            r_next.ub_n  = !r_reg.lanes[1];
            r_next.lb_n  = !r_reg.lanes[0];
          end
          r_next.cnt = 4'(PULSE_CYC);
          r_next.st  = DPSP_PULSE;
        end
      end

      DPSP_PULSE:
      begin
        // Busy low in secondary mode marks the memory write as blocked
        if (r_reg.wr && !busy_n_s[0] && !r_reg.flag)
          r_next.blocked = 1'b1;
        if (r_reg.cnt > CNT_ONE)
          r_next.cnt = r_reg.cnt - CNT_ONE;
        else
        begin
          // Flag read: bit 0 low means we own it
          r_next.rdata = data_s;
          // All strobes rise together; address and data still held
          r_next.sel_n = 1'b1;
          r_next.sem_n = 1'b1;
          r_next.ub_n  = 1'b1;
          r_next.lb_n  = 1'b1;
          r_next.we_n  = 1'b1;
          r_next.oe_n  = 1'b1;
          r_next.st    = DPSP_HOLD;
        end
      end

      DPSP_HOLD:
      begin
        // Bus let go a cycle after the strobe, for data hold margin
        r_next.doe = 1'b0;
        r_next.cnt = 4'(RECOV_CYC);
        r_next.st  = DPSP_RECOV;
      end

      DPSP_RECOV:
      begin
        // Strobes stay high so back-to-back cycles keep their gap
        if (r_reg.cnt > CNT_ONE)
          r_next.cnt = r_reg.cnt - CNT_ONE;
        else
        begin
          r_next.done  = 1'b1;
          r_next.ready = 1'b1;
          r_next.st    = DPSP_IDLE;
        end
      end

      default:
      begin
        // Unused codes fall back to idle
        r_next.st = DPSP_IDLE;
      end
    endcase
  end

  // State register; all strobe pins idle high after reset
  // Only strobes and ready start high; the rest clears
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      r_reg       <= '0;
      r_reg.st    <= DPSP_IDLE;
      r_reg.ready <= 1'b1;
      r_reg.sel_n <= 1'b1;
      r_reg.we_n  <= 1'b1;
      r_reg.oe_n  <= 1'b1;
      r_reg.ub_n  <= 1'b1;
      r_reg.lb_n  <= 1'b1;
      r_reg.sem_n <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // Outputs straight from flip-flops
  // No logic after the registers, so pins never glitch
  assign REQ_READY_OUT        = r_reg.ready;
  assign DONE_OUT             = r_reg.done;
  assign RDATA_OUT            = r_reg.rdata;
  assign BLOCKED_OUT          = r_reg.blocked;
  assign ADDR_OUT             = r_reg.addr;
  assign PORT_SEL_N_OUT       = r_reg.sel_n;
  assign WRITE_N_OUT          = r_reg.we_n;
  assign OUT_EN_N_OUT         = r_reg.oe_n;
  assign UPPER_LANE_SEL_N_OUT = r_reg.ub_n;
  assign LOWER_LANE_SEL_N_OUT = r_reg.lb_n;
  assign FLAG_SPACE_SEL_N_OUT = r_reg.sem_n;
  assign DATA_OUT             = r_reg.dout;
  assign DATA_OE_OUT          = r_reg.doe;
  // Flag races and same-address arbitration are settled in the memory;
  // this side only reports the outcome through read data and blocked
endmodule

// >>> dpsp_checker.sv
// Pin protocol assertions for the port controller
`timescale 1ns/10ps
module dpsp_checker
  import dpsp_pkg::*;
(
  // Clock, reset and user handshake
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_IN,
  input wire logic REQ_READY_OUT,
  input wire logic DONE_OUT,
  // Memory pins
  input wire logic [ADDR_W-1:0] ADDR_OUT,
  input wire logic PORT_SEL_N_OUT,
  input wire logic WRITE_N_OUT,
  input wire logic OUT_EN_N_OUT,
  input wire logic FLAG_SPACE_SEL_N_OUT,
  input wire logic DATA_OE_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Take, then strobe pulse of four cycles
  sequence s_take; REQ_IN && REQ_READY_OUT; endsequence
  sequence s_pulse; !WRITE_N_OUT [*4] ##1 WRITE_N_OUT; endsequence
  property p_rd; !OUT_EN_N_OUT |-> WRITE_N_OUT; endproperty
  a_rd: assert property (p_rd) else $error("strobe low in read");
  property p_mem; !PORT_SEL_N_OUT |-> FLAG_SPACE_SEL_N_OUT; endproperty
  a_mem: assert property (p_mem) else $error("both selects");
  property p_flg; !FLAG_SPACE_SEL_N_OUT |-> PORT_SEL_N_OUT; endproperty
  a_flg: assert property (p_flg) else $error("port sel in flag");
  property p_adr; !$stable(ADDR_OUT) |-> WRITE_N_OUT || PORT_SEL_N_OUT;
  endproperty
  a_adr: assert property (p_adr) else $error("address moved");
  property p_bus; DATA_OE_OUT |-> OUT_EN_N_OUT; endproperty
  a_bus: assert property (p_bus) else $error("bus fight");
  property p_hiz; !WRITE_N_OUT |-> OUT_EN_N_OUT; endproperty
  a_hiz: assert property (p_hiz) else $error("output on in write");
  property p_pls; $fell(WRITE_N_OUT) |-> s_pulse; endproperty
  a_pls: assert property (p_pls) else $error("pulse length");
  // Done follows the take after the full sequence, never early
  property p_done; s_take |=> !REQ_READY_OUT ##0 !DONE_OUT [*8] ##[1:3]
    DONE_OUT; endproperty
  a_done: assert property (p_done) else $error("done timing");
endmodule
bind dpsp_port_ctrl dpsp_checker i_dpsp_checker (.MCLK_IN, .RST_N_IN,
  .REQ_IN, .REQ_READY_OUT, .DONE_OUT, .ADDR_OUT, .PORT_SEL_N_OUT,
  .WRITE_N_OUT, .OUT_EN_N_OUT, .FLAG_SPACE_SEL_N_OUT, .DATA_OE_OUT);

// >>> dpsp_mem_model.sv
// Behavioural model of one port of the dual-port memory
`timescale 1ns/10ps
module dpsp_mem_model
  import dpsp_pkg::*;
(
  // Pins from the controller
  input wire logic [3:0] a_in,
  input wire logic cs_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [1:0] ln_n_in,
  input wire logic sem_n_in,
  input wire logic [DATA_W-1:0] d_in,
  input wire logic d_oe_in,
  // Far port holds the word
  input wire logic busy_in,
  // Wire levels back
  output logic [DATA_W-1:0] q_out,
  output logic busy_n_out
);
  logic [DATA_W-1:0] mem [16] = '{default: DATA_ZERO};
  logic [7:0] own = 8'h00;
  logic [DATA_W-1:0] junk = 16'h5a5a;
  logic ram, flag_space_sel_n, v;
  // Released lanes keep changing, stale data never matches
  always #4 junk = ~junk;
  assign ram = !cs_n_in && sem_n_in;
  assign flag_space_sel_n = cs_n_in && !sem_n_in;
  assign v = !oe_n_in && we_n_in;
  // Busy goes to this port only when the far port won the word
  assign busy_n_out = !busy_in;
  // Write in the overlap; busy blocks it
  always @*
    if (!we_n_in && ram && !busy_in && ln_n_in != 2'h3)
    begin
      if (!ln_n_in[1]) mem[a_in][15:8] = d_in[15:8];
      if (!ln_n_in[0]) mem[a_in][7:0] = d_in[7:0];
    end
    else if (!we_n_in && flag_space_sel_n && !ln_n_in[0])
      // Far port never contends here, so a request always wins
      own[a_in[2:0]] = !d_in[0];
  // Read drive, flag owned shows as low
  always_comb
    if (d_oe_in) q_out = d_in;
    else if (v && ram)
      q_out = {ln_n_in[1] ? junk[15:8] : mem[a_in][15:8],
               ln_n_in[0] ? junk[7:0] : mem[a_in][7:0]};
    else if (v && flag_space_sel_n) q_out = {junk[15:1], !own[a_in[2:0]]};
    else q_out = junk;
endmodule

// >>> tb_top.sv
// Self-checking bench for the port controller with the memory model
`timescale 1ns/10ps
module tb_top import dpsp_pkg::*;;
  logic clk, rst_n, req, wr, fl, busy, rdy, done, blk, cs_n, we_n, oe_n;
  logic ub_n, lb_n, sem_n, doe, bsy_n;
  logic [1:0] ln;
  logic [ADDR_W-1:0] adr, aout;
  logic [DATA_W-1:0] wd, rd, din, dout;
  logic [DATA_W-1:0] ref_mem [16] = '{default: DATA_ZERO};
  logic [7:0] ref_own = 8'h00;
  int mismatches = 0;
  int checks_done = 0;
  int i;
  dpsp_port_ctrl i_dpsp_port_ctrl (.MCLK_IN(clk), .RST_N_IN(rst_n),
    .REQ_IN(req), .REQ_WRITE_IN(wr), .REQ_FLAG_IN(fl), .REQ_LANES_IN(ln),
    .REQ_ADDR_IN(adr), .REQ_WDATA_IN(wd), .REQ_READY_OUT(rdy),
    .DONE_OUT(done), .RDATA_OUT(rd), .BLOCKED_OUT(blk), .ADDR_OUT(aout),
    .PORT_SEL_N_OUT(cs_n), .WRITE_N_OUT(we_n), .OUT_EN_N_OUT(oe_n),
    .UPPER_LANE_SEL_N_OUT(ub_n), .LOWER_LANE_SEL_N_OUT(lb_n),
    .FLAG_SPACE_SEL_N_OUT(sem_n), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE_OUT(doe), .BUSY_N_IN(bsy_n));
  dpsp_mem_model i_dpsp_mem_model (.a_in(aout[3:0]), .cs_n_in(cs_n),
    .we_n_in(we_n), .oe_n_in(oe_n), .ln_n_in({ub_n, lb_n}),
    .sem_n_in(sem_n), .d_in(dout), .d_oe_in(doe), .busy_in(busy),
    .q_out(din), .busy_n_out(bsy_n));
  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [DATA_W-1:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One request, raised for one cycle, then a bounded wait for done
  task automatic acc(input logic w, f, input logic [1:0] l,
                     input logic [3:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    fl <= f;
    ln <= l;
    adr <= {10'h000, a};
    wd <= d;
    @(posedge clk);
    req <= 1'b0;
    for (n = 0; n < 30 && done !== 1'b1; n++) @(posedge clk);
    if (n == 30)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // Operation with its reference update and comparison
  task automatic op(input int k, input logic [3:0] a,
                    input logic [DATA_W-1:0] d, input logic [1:0] l);
    logic [DATA_W-1:0] m;
    // Unselected lanes are left to the memory's floating bus
    m = {{8{l[1]}}, {8{l[0]}}};
    acc(k[0] == 1'b0, k[1], (k < 2) ? l : 2'h0, a, d);
    if (k == 0 && !busy && l[1]) ref_mem[a][15:8] = d[15:8];
    if (k == 0 && !busy && l[0]) ref_mem[a][7:0] = d[7:0];
    if (k == 0) chk("blocked", 16'(blk), 16'(busy));
    if (k == 1) chk("rdata", rd & m, ref_mem[a] & m);
    if (k == 2) ref_own[a[2:0]] = !d[0];
    if (k == 3) chk("flag", 16'(rd[0]), 16'(!ref_own[a[2:0]]));
  endtask
  // Reset, idle flags, random traffic, then a busy-blocked write
  initial
  begin
    {rst_n, req, wr, fl, busy, ln, adr, wd} = '0;
    void'($urandom(7443));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++) op(3, 4'(i), DATA_ZERO, 2'h0);
    for (i = 0; i < 80; i++)
      op($urandom % 4, 4'($urandom), 16'($urandom), 2'(1 + $urandom % 3));
    busy <= 1'b1;
    op(0, 4'h5, 16'hffff, 2'h3);
    busy <= 1'b0;
    op(1, 4'h5, DATA_ZERO, 2'h3);
    tally_and_finish();
  end
endmodule
